// >>> verilog/ptx_cfg.svh
// Purpose: constants of the pam5 transmit coder
// Assumes: 40 MHz system clock, one code-group per symbol strobe
// Notes: symbols are 3-bit two's complement values
`ifndef PTX_CFG_SVH
`define PTX_CFG_SVH

// timing
`define PTX_CLK_MHZ 40
`define PTX_SYM_PERIOD_NS 8
`define PTX_SYM_CYC_RAW ((`PTX_SYM_PERIOD_NS * `PTX_CLK_MHZ) / 1000)
`define PTX_SYM_CYCLES ((`PTX_SYM_CYC_RAW < 1) ? 1 : `PTX_SYM_CYC_RAW)

// scrambler
`define PTX_SCR_LEN 33
`define PTX_TAP_M 12
`define PTX_TAP_S 19
`define PTX_SCR_SEED 33'h0_2468_ace1

// register byte addresses
`define PTX_REG_CTRL 8'h00
`define PTX_REG_STATUS 8'h04
`define PTX_REG_SCR_LO 8'h08
`define PTX_REG_SCR_HI 8'h0c

// control fields and reset values
`define PTX_CTRL_RST_BIT 0
`define PTX_CTRL_COL_BIT 1
`define PTX_CTRL_EEE_BIT 2
`define PTX_CTRL_RST_RV 1'b0
`define PTX_CTRL_COL_RV 1'b1
`define PTX_CTRL_EEE_RV 1'b0

// symbol values
`define PTX_P2 3'sh2
`define PTX_P1 3'sh1
`define PTX_Z0 3'sh0
`define PTX_M1 3'sh7
`define PTX_M2 3'sh6

// fixed code-groups a,b,c,d packed msb first
`define PTX_CG_SSD1 12'h492
`define PTX_CG_SSD2 12'h496
`define PTX_CG_ERR 12'h090
`define PTX_CG_CSR 12'h4b2
`define PTX_CG_ESD 12'h4b6

`endif

// >>> verilog/ptx_pkg.sv
// Purpose: types of the pam5 transmit coder
// Assumes: constants live in ptx_cfg.svh
// Notes: none
package ptx_pkg;
  typedef enum logic [1:0] {PTX_SEND_N, PTX_SEND_I, PTX_SEND_Z} ptx_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SSD2, ST_DATA, ST_CSR2, ST_ESD1, ST_ESD2} ptx_fsm_t;
  typedef enum logic [3:0] {
    KIND_ZERO, KIND_IDLE, KIND_TRAIN, KIND_LPI, KIND_SSD, KIND_DATA, KIND_ERR, KIND_CSR, KIND_ESD
  } ptx_kind_t;
  typedef struct packed {
    logic signed [2:0] a;
    logic signed [2:0] b;
    logic signed [2:0] c;
    logic signed [2:0] d;
  } ptx_cg_t;
  typedef struct packed {
    logic [3:0] sx;
    logic [3:0] sy;
    logic [3:0] sg;
    logic x;
    logic y;
  } ptx_sbits_t;
  typedef struct packed {
    logic [7:0] txd;
    logic en;
    logic er;
  } ptx_gmii_t;
  typedef struct packed {
    ptx_mode_t mode;
    logic master;
    logic rcvr_ok;
    logic lpi_req;
    logic update_done;
  } ptx_pma_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ptx_bus_t;
  typedef struct packed {
    logic [32:0] scr;
  } ptx_scr_st_t;
endpackage

// >>> verilog/ptx_scrambler.sv
// Purpose: 33-bit side-stream scrambler and its derived bits
// Assumes: adv_i pulses once per symbol period
// Notes: derived bits are combinational from the current state
`timescale 1ns/1ps
`include "ptx_cfg.svh"
module ptx_scrambler import ptx_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // control
  input wire logic init_i,
  input wire logic adv_i,
  input wire logic master_i,
  // state and derived bits
  output logic [32:0] scr_o,
  output ptx_sbits_t bits_o
);
  ptx_scr_st_t st_reg;
  ptx_scr_st_t st_next;
  logic fb;
  logic [32:0] s;

  assign s = st_reg.scr;

  always_comb begin
    st_next = st_reg;
    fb = s[`PTX_SCR_LEN-1] ^ (master_i ? s[`PTX_TAP_M] : s[`PTX_TAP_S]);
    // an all-zero state would lock up, so it is reloaded as well
    if (init_i || (s == 33'h0_0000_0000)) begin
      st_next.scr = `PTX_SCR_SEED;
    end else if (adv_i) begin
      st_next.scr = {s[31:0], fb};
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg.scr <= `PTX_SCR_SEED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign scr_o = s;
  assign bits_o.x = s[4] ^ s[6];
  assign bits_o.y = s[1] ^ s[5];
  assign bits_o.sy = {s[9] ^ s[14] ^ s[19] ^ s[24], s[6] ^ s[16], s[3] ^ s[8], s[0]};
  assign bits_o.sx = {s[13] ^ s[15] ^ s[18] ^ s[20] ^ s[23] ^ s[25] ^ s[28] ^ s[30],
                      s[10] ^ s[12] ^ s[20] ^ s[22], s[7] ^ s[9] ^ s[12] ^ s[14], s[4] ^ s[6]};
  assign bits_o.sg = {s[10] ^ s[14] ^ s[15] ^ s[29], s[7] ^ s[11] ^ s[17] ^ s[21],
                      s[4] ^ s[8] ^ s[9] ^ s[13], s[1] ^ s[5]};
endmodule

// >>> verilog/ptx_transmit.sv
// Purpose: pam5 transmit coder, gmii octets to four-symbol code-groups
// Assumes: gmii and pma controls come from logic on clk_sys_i
// Notes: symbol maps and fixed code-groups are simplified stand-ins
`timescale 1ns/1ps
`include "ptx_cfg.svh"
module ptx_transmit import ptx_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // gmii transmit side and receive activity
  input wire ptx_gmii_t gmii_i,
  input wire logic rx_active_i,
  output logic col_o,
  // pma controls and code-group
  input wire ptx_pma_t pma_i,
  output ptx_cg_t cg_o,
  output ptx_kind_t cg_kind_o,
  output logic cg_valid_o,
  // register port
  input wire ptx_bus_t bus_i,
  output logic [31:0] rdata_o
);
  typedef struct packed {
    ptx_fsm_t fsm;
    logic ssd_err;
    logic [2:0] cs;
    ptx_cg_t cg;
    ptx_kind_t kind;
    logic valid;
    logic col;
    logic [3:0] cnt;
    logic soft_rst;
    logic col_en;
    logic eee_en;
    logic [31:0] rdata;
  } ptx_st_t;

  ptx_st_t st_reg;
  ptx_st_t st_next;
  ptx_sbits_t sb;
  logic [32:0] scr;
  logic tick;
  logic tx_enable;
  logic tx_error;
  logic [7:0] sc;
  logic [7:0] dat;
  logic [7:0] iw;
  ptx_cg_t cg;
  ptx_kind_t kind;
  logic invert;
  logic [31:0] status_w;

  // idle-style symbol from two scrambler bits, only +2, 0 or -2
  function automatic logic signed [2:0] ptx_tern(input logic [1:0] w);
    case (w)
      2'h1: ptx_tern = `PTX_P2;
      2'h2: ptx_tern = `PTX_M2;
      default: ptx_tern = `PTX_Z0;
    endcase
  endfunction

  // data symbol from two scrambled data bits
  function automatic logic signed [2:0] ptx_quin(input logic [1:0] w);
    case (w)
      2'h0: ptx_quin = `PTX_M2;
      2'h1: ptx_quin = `PTX_M1;
      2'h2: ptx_quin = `PTX_P1;
      default: ptx_quin = `PTX_P2;
    endcase
  endfunction

  function automatic ptx_cg_t ptx_idle_cg(input logic [7:0] w);
    ptx_cg_t r;
    r.a = ptx_tern(w[1:0]);
    r.b = ptx_tern(w[3:2]);
    r.c = ptx_tern(w[5:4]);
    r.d = ptx_tern(w[7:6]);
    return r;
  endfunction

  function automatic logic signed [2:0] ptx_neg(input logic signed [2:0] v, input logic n);
    ptx_neg = n ? 3'(-v) : v;
  endfunction

  // sign randomising per pair, with the idle-class inversion on top
  function automatic ptx_cg_t ptx_sign_cg(input ptx_cg_t g, input logic [3:0] sg, input logic inv);
    ptx_cg_t r;
    r.a = ptx_neg(g.a, sg[0] ^ inv);
    r.b = ptx_neg(g.b, sg[1] ^ inv);
    r.c = ptx_neg(g.c, sg[2] ^ inv);
    r.d = ptx_neg(g.d, sg[3] ^ inv);
    return r;
  endfunction

  // data group: pair a carries the low bit pair, pair d the high one
  function automatic ptx_cg_t ptx_data_cg(input logic [7:0] w, input logic cs0);
    ptx_cg_t r;
    r.a = ptx_neg(ptx_quin(w[1:0]), cs0);
    r.b = ptx_quin(w[3:2]);
    r.c = ptx_quin(w[5:4]);
    r.d = ptx_quin(w[7:6]);
    return r;
  endfunction

  // three-bit encoder steps on the two scrambled top bits
  function automatic logic [2:0] ptx_cs_step(input logic [2:0] cs, input logic [1:0] top);
    ptx_cs_step = {cs[1] ^ top[1], cs[0] ^ top[0], cs[2]};
  endfunction

  // training folds the low half onto the high half, so only idle-class symbols appear
  function automatic ptx_cg_t ptx_train_cg(input logic [7:0] w);
    return ptx_idle_cg({w[7:4] ^ w[3:0], w[3:0]});
  endfunction

  // the scrambler runs in every mode, so its phase never depends on mode history
  ptx_scrambler u_scr (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .init_i(st_reg.soft_rst),
    .adv_i(tick),
    .master_i(pma_i.master),
    .scr_o(scr),
    .bits_o(sb)
  );

  // one strobe per symbol period; at 40 MHz every edge is a period
  assign tick = (st_reg.cnt == 4'(`PTX_SYM_CYCLES - 1));

  // enabling process: only normal mode may carry a frame
  assign tx_enable = gmii_i.en && (pma_i.mode == PTX_SEND_N);
  assign tx_error = gmii_i.er && (pma_i.mode == PTX_SEND_N);

  assign sc = {sb.sx, sb.sy};
  assign dat = gmii_i.txd ^ sc;

  // status is read live so software sees the group now on the pins
  assign status_w = {22'h0, st_reg.kind, st_reg.fsm, st_reg.cs[0], tx_enable, st_reg.col};

  always_comb begin
    st_next = st_reg;
    cg = '0;
    kind = KIND_ZERO;
    invert = 1'b0;
    iw = sc;

    st_next.cnt = tick ? 4'h0 : 4'(st_reg.cnt + 4'h1);
    // valid marks a fresh group and stays low under soft reset
    st_next.valid = tick && !st_reg.soft_rst;
    // col_en low keeps col quiet in a full-duplex-only build
    st_next.col = st_reg.col_en && rx_active_i && tx_enable;

    // receiver status and low-power flags ride on idle bits
    iw[2] = sc[2] ^ pma_i.rcvr_ok;
    if (st_reg.eee_en) begin
      iw[3] = sc[3] ^ pma_i.lpi_req;
      iw[1] = sc[1] ^ pma_i.update_done;
    end

    case (pma_i.mode)
      PTX_SEND_Z: begin
        kind = KIND_ZERO;
      end
      PTX_SEND_I: begin
        cg = ptx_train_cg(iw);
        kind = KIND_TRAIN;
        invert = 1'b1;
      end
      default: begin
        // normal mode, one group per octet time
        case (st_reg.fsm)
          ST_IDLE: begin
            if (tx_enable) begin
              cg = `PTX_CG_SSD1;
              kind = KIND_SSD;
              invert = 1'b1;
            end else begin
              cg = ptx_idle_cg(iw);
              kind = (st_reg.eee_en && pma_i.lpi_req) ? KIND_LPI : KIND_IDLE;
              invert = 1'b1;
            end
          end
          ST_SSD2: begin
            // en dropping inside the delimiter is closed the same way as an error
            if (st_reg.ssd_err || tx_error || !tx_enable) begin
              cg = `PTX_CG_CSR;
              kind = KIND_CSR;
            end else begin
              cg = `PTX_CG_SSD2;
              kind = KIND_SSD;
              invert = 1'b1;
            end
          end
          ST_DATA: begin
            // frame end wins: an error octet is not sent once en has fallen
            if (!tx_enable) begin
              cg = `PTX_CG_CSR;
              kind = KIND_CSR;
            end else if (tx_error) begin
              cg = `PTX_CG_ERR;
              kind = KIND_ERR;
            end else begin
              cg = ptx_data_cg(dat, st_reg.cs[0]);
              kind = KIND_DATA;
            end
          end
          ST_CSR2: begin
            cg = `PTX_CG_CSR;
            kind = KIND_CSR;
          end
          default: begin
            cg = `PTX_CG_ESD;
            kind = KIND_ESD;
          end
        endcase
      end
    endcase

    if (tick) begin
      // sign randomising, then the idle-class inversion
      st_next.cg = ptx_sign_cg(cg, sb.sg, invert);
      st_next.kind = kind;
      // leaving normal mode abandons a frame; no end delimiter follows
      if (pma_i.mode != PTX_SEND_N) begin
        st_next.fsm = ST_IDLE;
        st_next.ssd_err = 1'b0;
        st_next.cs = 3'h0;
      end else begin
        case (st_reg.fsm)
          ST_IDLE: begin
            if (tx_enable) begin
              st_next.fsm = ST_SSD2;
              st_next.ssd_err = tx_error;
            end
          end
          ST_SSD2: begin
            st_next.fsm = (kind == KIND_CSR) ? ST_CSR2 : ST_DATA;
            st_next.ssd_err = 1'b0;
          end
          ST_DATA: begin
            if (kind == KIND_CSR) begin
              st_next.fsm = ST_CSR2;
              st_next.cs = 3'h0;
            end else if (kind == KIND_DATA) begin
              st_next.cs = ptx_cs_step(st_reg.cs, dat[7:6]);
            end
          end
          ST_CSR2: begin
            st_next.fsm = ST_ESD1;
          end
          ST_ESD1: begin
            st_next.fsm = ST_ESD2;
          end
          default: begin
            st_next.fsm = ST_IDLE;
            st_next.cs = 3'h0;
          end
        endcase
      end
    end

    // management reset holds every piece of transmit state in reset
    if (st_reg.soft_rst) begin
      st_next.fsm = ST_IDLE;
      st_next.ssd_err = 1'b0;
      st_next.cs = 3'h0;
      st_next.cg = '0;
      st_next.kind = KIND_ZERO;
      st_next.col = 1'b0;
      st_next.cnt = 4'h0;
    end

    // a write takes effect at the edge that samples it
    if (bus_i.wr && (bus_i.addr == `PTX_REG_CTRL)) begin
      st_next.soft_rst = bus_i.wdata[`PTX_CTRL_RST_BIT];
      st_next.col_en = bus_i.wdata[`PTX_CTRL_COL_BIT];
      st_next.eee_en = bus_i.wdata[`PTX_CTRL_EEE_BIT];
    end

    // read data stand from the edge after the strobe until the next read
    if (bus_i.rd) begin
      case (bus_i.addr)
        `PTX_REG_CTRL: st_next.rdata = {29'h0, st_reg.eee_en, st_reg.col_en, st_reg.soft_rst};
        `PTX_REG_STATUS: st_next.rdata = status_w;
        `PTX_REG_SCR_LO: st_next.rdata = scr[31:0];
        `PTX_REG_SCR_HI: st_next.rdata = {31'h0, scr[32]};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // the asynchronous branch loads constants only; soft reset lives in the next-state logic
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg.fsm <= ST_IDLE;
      st_reg.ssd_err <= 1'b0;
      st_reg.cs <= 3'h0;
      st_reg.cg <= '0;
      st_reg.kind <= KIND_ZERO;
      st_reg.valid <= 1'b0;
      st_reg.col <= 1'b0;
      st_reg.cnt <= 4'h0;
      st_reg.soft_rst <= `PTX_CTRL_RST_RV;
      st_reg.col_en <= `PTX_CTRL_COL_RV;
      st_reg.eee_en <= `PTX_CTRL_EEE_RV;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cg_o = st_reg.cg;
  assign cg_kind_o = st_reg.kind;
  assign cg_valid_o = st_reg.valid;
  assign col_o = st_reg.col;
  assign rdata_o = st_reg.rdata;
endmodule

// >>> sim/ptx_transmit_properties.sv
// Purpose: port checks of the pam5 transmit coder
// Assumes: one clock, asynchronous active-low reset
// Notes: +2, 0 and -2 are the even 3-bit codes besides -4, so legality is a lsb test
`timescale 1ns/1ps
module ptx_transmit_chk import ptx_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // stream side
  input wire ptx_gmii_t gmii_i,
  input wire logic rx_active_i,
  input wire logic col_o,
  input wire ptx_pma_t pma_i,
  input wire ptx_cg_t cg_o,
  input wire ptx_kind_t cg_kind_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  logic n_mode;
  logic even;
  assign n_mode = pma_i.mode == PTX_SEND_N;
  assign even = !(cg_o.a[0] | cg_o.b[0] | cg_o.c[0] | cg_o.d[0]);
  AST_ZERO_OUT: assert property (pma_i.mode == PTX_SEND_Z |=> cg_o == '0 && cg_kind_o == KIND_ZERO)
    else $error("zero mode gave a nonzero group");
  AST_TRAIN_SYMS: assert property (pma_i.mode == PTX_SEND_I |=> even)
    else $error("training symbol outside +2 0 -2");
  AST_IDLE_SYMS: assert property (cg_kind_o == KIND_IDLE |-> even)
    else $error("idle symbol outside +2 0 -2");
  AST_COL_CAUSE: assert property (col_o |-> $past(rx_active_i))
    else $error("collision without receive");
  AST_COL_SET: assert property (rx_active_i && gmii_i.en && n_mode && cg_kind_o == KIND_DATA |=> col_o)
    else $error("collision missed");
  AST_SSD_PAIR: assert property (n_mode && gmii_i.en && !gmii_i.er && !$past(gmii_i.en) && cg_kind_o == KIND_IDLE
    ##1 n_mode && gmii_i.en && !gmii_i.er |-> cg_kind_o == KIND_SSD ##1 cg_kind_o == KIND_SSD)
    else $error("start delimiter not two groups");
  AST_DATA_AFTER_SSD: assert property ($past(cg_kind_o) == KIND_SSD && cg_kind_o == KIND_SSD && n_mode
    && gmii_i.en && !gmii_i.er |=> cg_kind_o == KIND_DATA)
    else $error("no data after delimiter");
  AST_ERR_DATA: assert property (cg_kind_o inside {KIND_DATA, KIND_ERR} && n_mode && gmii_i.en && gmii_i.er
    |=> cg_kind_o == KIND_ERR)
    else $error("error octet not flagged");
  AST_CSR_END: assert property (cg_kind_o inside {KIND_DATA, KIND_ERR} && n_mode && !gmii_i.en
    |=> cg_kind_o == KIND_CSR)
    else $error("frame end without reset group");
  AST_ESD_PAIR: assert property (cg_kind_o == KIND_ESD && $past(cg_kind_o) == KIND_CSR && n_mode
    |-> $past(cg_kind_o, 2) == KIND_CSR ##1 cg_kind_o == KIND_ESD)
    else $error("end delimiter sequence broken");
  cover property (cg_kind_o == KIND_ERR);
  cover property (col_o);
  cover property (cg_kind_o == KIND_ESD);
endmodule

// >>> sim/ptx_gmii_src.sv
// Purpose: gmii source feeding the coder one frame per command
// Assumes: go_i is one cycle long
// Notes: data line toggles between frames so a stale octet is never reused
`timescale 1ns/1ps
module ptx_gmii_src import ptx_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // command
  input wire logic go_i,
  input wire logic [7:0] len_i,
  input wire logic [7:0] err_at_i,
  // gmii out
  output ptx_gmii_t gmii_o
);
  logic [7:0] left_reg;
  logic [7:0] idx_reg;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left_reg <= 8'h00;
      idx_reg <= 8'h00;
      gmii_o <= '0;
    end else if (go_i) begin
      left_reg <= len_i;
      idx_reg <= 8'h00;
    end else if (left_reg != 8'h00) begin
      gmii_o <= '{txd: 8'ha5 + idx_reg, en: 1'b1, er: idx_reg == err_at_i};
      left_reg <= left_reg - 8'h01;
      idx_reg <= idx_reg + 8'h01;
    end else begin
      gmii_o <= '{txd: ~gmii_o.txd, en: 1'b0, er: 1'b0};
    end
  end
endmodule

// >>> sim/test_pam5_pcs_transmit_scrambler.sv
// Purpose: self-checking bench of the pam5 transmit coder
// Assumes: one group per clock, register map of the hand-over
// Notes: symbol maps are stand-ins, so frames are judged by group kind
`timescale 1ns/1ps
`include "ptx_cfg.svh"
module test_pam5_pcs_transmit_scrambler import ptx_pkg::*;;
  logic clk_sys_i;
  logic reset_n_i;
  logic rx_active_i;
  logic col_o;
  logic go;
  logic [7:0] len;
  logic [7:0] err_at;
  logic [31:0] rdata_o;
  logic cg_valid_o;
  ptx_gmii_t gmii;
  ptx_pma_t pma_i;
  ptx_bus_t bus_i;
  ptx_cg_t cg_o;
  ptx_kind_t cg_kind_o;
  int errors;
  int tests_run;
  ptx_gmii_src src (.clk_sys_i, .reset_n_i, .go_i(go), .len_i(len), .err_at_i(err_at), .gmii_o(gmii));
  ptx_transmit DUT (.clk_sys_i, .reset_n_i, .gmii_i(gmii), .rx_active_i, .col_o, .pma_i, .cg_o, .cg_kind_o,
    .cg_valid_o, .bus_i, .rdata_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic complete_run();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bad(string m);
    errors++;
    $display("BAD t=%0t %s", $time, m);
  endtask
  task automatic chk_bits(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) bad("value mismatch");
  endtask
  task automatic chk_kind(ptx_kind_t got, ptx_kind_t exp);
    tests_run++;
    if (got !== exp) bad("group kind mismatch");
  endtask
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_i.rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  // soft reset parks the scrambler on its seed so it can be read still
  task automatic seed_check();
    logic [31:0] v;
    logic [32:0] s;
    s = `PTX_SCR_SEED;
    rd(8'h00, v);
    chk_bits(v, 32'h2);
    wr(8'h00, 32'h3);
    rd(8'h08, v);
    chk_bits(v, s[31:0]);
    rd(8'h0c, v);
    chk_bits(v, {31'h0, s[32]});
    rd(8'h10, v);
    chk_bits(v, 32'h0);
    chk_bits({31'h0, cg_valid_o}, 32'h0);
    wr(8'h00, 32'h2);
  endtask
  // four back-to-back reads see four consecutive states
  task automatic scr_walk(logic m);
    logic [7:0] a[5];
    logic [31:0] v[4];
    a = '{8'h08, 8'h0c, 8'h08, 8'h08, 8'h00};
    @(posedge clk_sys_i);
    pma_i.master <= m;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys_i);
      bus_i <= '{addr: a[i], wdata: 32'h0, wr: 1'b0, rd: i < 4};
      #1;
      if (i > 0) v[i - 1] = rdata_o;
    end
    chk_bits(v[1], {31'h0, v[0][31]});
    chk_bits({v[2][31:2], 2'b00}, {v[0][29:0], 2'b00});
    chk_bits({31'h0, v[3][0]}, {31'h0, v[2][m ? 12 : 19] ^ v[0][30]});
  endtask
  task automatic mode_check(ptx_mode_t m);
    ptx_kind_t k[3];
    k = '{KIND_IDLE, KIND_TRAIN, KIND_ZERO};
    @(posedge clk_sys_i);
    pma_i.mode <= m;
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_i);
      pma_i.rcvr_ok <= i[0];
      #1;
      chk_kind(cg_kind_o, k[m]);
      chk_bits({20'h0, cg_o & (m == PTX_SEND_Z ? 12'hfff : 12'h249)}, 32'h0);
      chk_bits({31'h0, cg_valid_o}, 32'h1);
    end
  endtask
  // low-power idle is announced only while the feature is enabled
  task automatic lpi_check();
    wr(8'h00, 32'h6);
    @(posedge clk_sys_i);
    pma_i.lpi_req <= 1'b1;
    repeat (2) tick();
    chk_kind(cg_kind_o, KIND_LPI);
    chk_bits({20'h0, cg_o & 12'h249}, 32'h0);
    wr(8'h00, 32'h2);
    tick();
    chk_kind(cg_kind_o, KIND_IDLE);
    @(posedge clk_sys_i);
    pma_i.lpi_req <= 1'b0;
  endtask
  task automatic frame(logic [7:0] n, logic [7:0] e, logic rx, ptx_kind_t exp[$]);
    logic col_seen;
    int w;
    col_seen = 1'b0;
    w = 0;
    @(posedge clk_sys_i);
    go <= 1'b1;
    len <= n;
    err_at <= e;
    rx_active_i <= rx;
    @(posedge clk_sys_i);
    go <= 1'b0;
    #1;
    while (cg_kind_o !== exp[0] && w < 12) begin
      if (cg_kind_o === KIND_DATA) bad("data before expected group");
      tick();
      w++;
    end
    if (w == 12) begin
      bad("expected group never came");
      complete_run();
    end
    foreach (exp[i]) begin
      chk_kind(cg_kind_o, exp[i]);
      col_seen |= col_o;
      tick();
    end
    chk_bits({31'h0, col_seen}, {31'h0, rx});
  endtask
  initial begin
    errors = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    rx_active_i = 1'b0;
    go = 1'b0;
    len = 8'h00;
    err_at = 8'hff;
    pma_i = '{mode: PTX_SEND_N, master: 1'b1, rcvr_ok: 1'b1, lpi_req: 1'b0, update_done: 1'b1};
    bus_i = '0;
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    seed_check();
    scr_walk(1'b1);
    scr_walk(1'b0);
    for (int m = 2; m >= 0; m--) mode_check(ptx_mode_t'(m));
    lpi_check();
    frame(8'h05, 8'hff, 1'b1, '{KIND_SSD, KIND_SSD, KIND_DATA, KIND_DATA, KIND_DATA, KIND_CSR, KIND_CSR,
      KIND_ESD, KIND_ESD, KIND_IDLE});
    frame(8'h06, 8'h03, 1'b0, '{KIND_SSD, KIND_SSD, KIND_DATA, KIND_ERR, KIND_DATA, KIND_DATA, KIND_CSR,
      KIND_CSR, KIND_ESD, KIND_ESD, KIND_IDLE});
    frame(8'h04, 8'h01, 1'b0, '{KIND_SSD, KIND_CSR, KIND_CSR, KIND_ESD, KIND_ESD, KIND_IDLE});
    complete_run();
  end
endmodule
bind ptx_transmit ptx_transmit_chk u_chk (.clk_sys_i, .reset_n_i, .gmii_i, .rx_active_i, .col_o, .pma_i,
  .cg_o, .cg_kind_o);
